// file: sfr_page_stack_consts.vh
/*
 * constants for the page select stack: register offsets, field positions,
 * reset values and stack geometry.
 * assumes an 8-bit register port with one-cycle read latency.
 */
// Behaviour
// R1 - with auto paging on, interrupt entry pushes the active page onto the stack
// R2 - on entry the active page becomes the interrupting source's page
// R3 - with auto paging on, interrupt exit pops and restores the saved page
// R4 - pop moves level 1 to active page and every deeper level up one
// R5 - index bits 6:4 pick level shown by stack view; 000 top, 100 bottom
// R6 - control bit 0 enables push and pop; 0 disables them
// R7 - software writes zero to reserved bits 7 and 3:1; they read zero
`ifndef SFR_PAGE_STACK_CONSTS_VH
`define SFR_PAGE_STACK_CONSTS_VH

`define PSC_ADDR_CONTROL     8'hcf
`define PSC_ADDR_ACTIVE_PAGE 8'ha7
`define PSC_ADDR_STACK_VIEW  8'hd7

`define PSC_BIT_ENABLE       0
`define PSC_IDX_LSB          4
`define PSC_IDX_MSB          6

`define PSC_CONTROL_RESET    8'h01
`define PSC_PAGE_RESET       8'h00

`define PSC_STACK_LEVELS     5

`endif

// file: sfr_page_stack.v
/*
 * page select register with a five-level hardware stack. interrupt entry
 * pushes the active page and loads the source page; interrupt return pops.
 * assumes entry and exit are one-cycle pulses from the interrupt logic and
 * that the register port is driven synchronously to ref_clk_in.
 */
`include "sfr_page_stack_consts.vh"
`timescale 1ns/10ps
`default_nettype none

module sfr_page_stack #(
    parameter LEVELS = `PSC_STACK_LEVELS,
    parameter PAGE_W = 8
) (
    input  wire              ref_clk_in,      // system clock
    input  wire              sys_rst_in,      // synchronous reset, active high
    input  wire              clk_en_in,       // freezes all state while low
    input  wire [7:0]        reg_addr_in,     // register address
    input  wire [7:0]        reg_wdata_in,    // register write data
    input  wire              reg_wr_in,       // write strobe
    input  wire              reg_rd_in,       // read strobe
    output reg  [7:0]        reg_rdata_out,   // read data, cycle after strobe
    input  wire              isr_entry_in,    // interrupt entry pulse
    input  wire [PAGE_W-1:0] isr_page_in,     // page of interrupting source
    input  wire              isr_exit_in,     // return_from_interrupt pulse
    output reg  [PAGE_W-1:0] active_page_out, // active_page_select
    output reg               auto_en_out      // auto_paging_enable
);

    ////////////////////////////////////////////////////////////////////////
    // local constants

    // width of the level index field in the control register
    localparam IDX_W = 3;

    // deepest stack level; a pop refills it with the reset page
    localparam LAST  = LEVELS - 1;

    // reset images, cut to the widths of the registers that take them
    localparam [7:0]        CTRL_RST  = `PSC_CONTROL_RESET;
    localparam [PAGE_W-1:0] PAGE_RST  = `PSC_PAGE_RESET;

    // register offsets on the port
    localparam [7:0]        ADDR_CTL  = `PSC_ADDR_CONTROL;
    localparam [7:0]        ADDR_PAGE = `PSC_ADDR_ACTIVE_PAGE;
    localparam [7:0]        ADDR_VIEW = `PSC_ADDR_STACK_VIEW;

    ////////////////////////////////////////////////////////////////////////
    // decoding helpers

    // true when the port address selects the given register
    function hits;
        input [7:0] addr;
        input [7:0] target;
        begin
            hits = (addr == target);
        end
    endfunction

    // true for index codes that name a real stack level
    function level_ok;
        input [IDX_W-1:0] idx;
        begin
            level_ok = ({29'h0, idx} < LEVELS);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // declarations

    // control register fields
    reg  [IDX_W-1:0]         stack_level_index_r;
    reg  [IDX_W-1:0]         stack_level_index_nxt;
    reg                      auto_en_nxt;

    // all stack levels side by side, level 0 in the low bits
    wire [PAGE_W*LEVELS-1:0] stack_flat;

    // read path
    reg  [PAGE_W-1:0]        view_sel;
    reg  [7:0]               rdata_nxt;

    // decoded strobes
    wire                     wr_ctl;
    wire                     wr_page;
    wire                     push;
    wire                     pop;

    ////////////////////////////////////////////////////////////////////////
    // strobe decode

    assign wr_ctl  = reg_wr_in && hits(reg_addr_in, ADDR_CTL);
    assign wr_page = reg_wr_in && hits(reg_addr_in, ADDR_PAGE);

    // entry wins when entry and exit land in one cycle
    assign push    = auto_en_out && isr_entry_in;                 // R1 R6
    assign pop     = auto_en_out && isr_exit_in && !isr_entry_in; // R3 R6

    ////////////////////////////////////////////////////////////////////////
    // control register

    // reserved bits are dropped here, so they can never read back as one
    always @* begin
        auto_en_nxt           = auto_en_out;
        stack_level_index_nxt = stack_level_index_r;
        if (wr_ctl) begin
            auto_en_nxt           = reg_wdata_in[`PSC_BIT_ENABLE];           // R6
            stack_level_index_nxt = reg_wdata_in[`PSC_IDX_MSB:`PSC_IDX_LSB]; // R5
        end
    end

    // a push in the same cycle as a control write still uses the old enable
    always @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            auto_en_out         <= CTRL_RST[`PSC_BIT_ENABLE];
            stack_level_index_r <= CTRL_RST[`PSC_IDX_MSB:`PSC_IDX_LSB];
        end else if (clk_en_in) begin
            auto_en_out         <= auto_en_nxt;
            stack_level_index_r <= stack_level_index_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // page stack

    // every level has the same shape: a push takes the value from the level
    // above, a pop the value from the level below. level 0 is the active
    // page and takes the source page on a push. a push beyond the depth
    // drops the bottom level; a pop fills the bottom with the reset page.

    genvar g;

    generate
        for (g = 0; g < LEVELS; g = g + 1) begin : level
            wire [PAGE_W-1:0] shallower;   // value a push moves in
            wire [PAGE_W-1:0] deeper;      // value a pop moves in
            reg  [PAGE_W-1:0] level_r;     // stored page of this level
            reg  [PAGE_W-1:0] level_nxt;   // next value of this level

            if (g == 0) begin : top
                assign shallower = isr_page_in;                           // R2
            end else begin : inner
                assign shallower = stack_flat[(g-1)*PAGE_W +: PAGE_W];    // R1
            end

            if (g == LAST) begin : bottom
                assign deeper = PAGE_RST;
            end else begin : upper
                assign deeper = stack_flat[(g+1)*PAGE_W +: PAGE_W];       // R4
            end

            // a software page write loses against a push or pop
            always @* begin
                level_nxt = level_r;
                if (push) begin
                    level_nxt = shallower;
                end else if (pop) begin
                    level_nxt = deeper;                                   // R3 R4
                end else if ((g == 0) && wr_page) begin
                    level_nxt = reg_wdata_in[PAGE_W-1:0];
                end
            end

            always @(posedge ref_clk_in) begin
                if (sys_rst_in) begin
                    level_r <= PAGE_RST;
                end else if (clk_en_in) begin
                    level_r <= level_nxt;
                end
            end

            assign stack_flat[g*PAGE_W +: PAGE_W] = level_r;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // active page

    // level 0 is a flip-flop, so this output is registered
    always @* begin
        active_page_out = stack_flat[PAGE_W-1:0];
    end

    ////////////////////////////////////////////////////////////////////////
    // stack view

    // invalid index codes show zero rather than a stale level
    always @* begin
        if (level_ok(stack_level_index_r)) begin
            view_sel = stack_flat[stack_level_index_r*PAGE_W +: PAGE_W];  // R5
        end else begin
            view_sel = {PAGE_W{1'b0}};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read port

    // read data stand for one cycle after the strobe, zero otherwise
    always @* begin
        rdata_nxt = 8'h00;
        if (reg_rd_in) begin
            if (hits(reg_addr_in, ADDR_CTL)) begin
                rdata_nxt = {1'b0, stack_level_index_r, 3'h0, auto_en_out}; // R7
            end else if (hits(reg_addr_in, ADDR_PAGE)) begin
                rdata_nxt[PAGE_W-1:0] = stack_flat[PAGE_W-1:0];
            end else if (hits(reg_addr_in, ADDR_VIEW)) begin
                rdata_nxt[PAGE_W-1:0] = view_sel;
            end
        end
    end

    // frozen with the rest of the state while the clock enable is low
    always @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            reg_rdata_out <= 8'h00;
        end else if (clk_en_in) begin
            reg_rdata_out <= rdata_nxt;
        end
    end

endmodule

`default_nettype wire

// file: sfr_page_stack_monitor.sv
/* port assertions for sfr_page_stack; assumes one clock domain */
`timescale 1ns/10ps
`default_nettype none
module sfr_page_stack_monitor (
    input wire logic ref_clk_in, sys_rst_in, clk_en_in, reg_wr_in, reg_rd_in,
    input wire logic isr_entry_in, isr_exit_in, auto_en_out,
    input wire logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, isr_page_in, active_page_out
);
default clocking @(posedge ref_clk_in); endclocking
default disable iff (sys_rst_in);
wire push = isr_entry_in && clk_en_in && auto_en_out;
page_load_a: assert property (push |=> active_page_out == $past(isr_page_in))
    else $error("page not loaded");
page_pop_a: assert property (push ##1 (!isr_entry_in && !isr_exit_in && !reg_wr_in)
    ##1 (isr_exit_in && !isr_entry_in && auto_en_out && clk_en_in)
    |=> active_page_out == $past(active_page_out, 3)) else $error("page not restored");
page_hold_a: assert property (!auto_en_out && !reg_wr_in |=> $stable(active_page_out))
    else $error("page moved");
enable_write_a: assert property (reg_wr_in && clk_en_in && reg_addr_in == 8'hcf
    |=> auto_en_out == $past(reg_wdata_in[0])) else $error("enable wrong");
control_read_a: assert property (reg_rd_in && clk_en_in && reg_addr_in == 8'hcf
    |=> reg_rdata_out[0] == auto_en_out && reg_rdata_out[3:1] == 3'h0) else $error("bad read");
read_quiet_a: assert property (reg_rdata_out != 8'h00 |-> $past(reg_rd_in))
    else $error("stray data");
endmodule
bind sfr_page_stack sfr_page_stack_monitor mon (.*);
`default_nettype wire

// file: isr_source.sv
/* interrupt side: one-cycle entry or exit pulse; page not held after */
`timescale 1ns/10ps
`default_nettype none
module isr_source (input wire logic ref_clk_in,
    output logic isr_entry_in = 0, isr_exit_in = 0, output logic [7:0] isr_page_in = 0);
task fire(bit x, logic [7:0] p); @(posedge ref_clk_in);
    {isr_entry_in, isr_exit_in, isr_page_in} <= {!x, x, p}; @(posedge ref_clk_in);
    {isr_entry_in, isr_exit_in, isr_page_in} <= {2'b00, ~p}; endtask
endmodule
`default_nettype wire

// file: testbench.sv
/* bench with a stack model; isr_source drives the interrupt side */
`timescale 1ns/10ps
`default_nettype none
module testbench;
logic ref_clk_in = 0, sys_rst_in = 1, clk_en_in = 1, reg_wr_in = 0, reg_rd_in = 0, en = 1;
logic isr_entry_in, isr_exit_in, auto_en_out;
logic [7:0] reg_addr_in = 0, reg_wdata_in = 0, reg_rdata_out, isr_page_in, active_page_out;
logic [7:0] s[5] = '{default: 8'h00};
logic [15:0] r = 16'h643d;
int mismatches = 0, comparisons = 0, cyc = 0, i, j;
always #12.5 ref_clk_in = ~ref_clk_in;
sfr_page_stack DUT (.*);
isr_source src (.*);
task t; @(posedge ref_clk_in); endtask
task test_done; $display("%0d compared, %0d failed", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish; endtask
always @(posedge ref_clk_in) if (++cyc > 2000) begin mismatches++; test_done; end
function logic [15:0] nx(logic [15:0] v); return {v[14:0], v[15]^v[13]^v[12]^v[10]}; endfunction
task cmp(string n, logic [7:0] e, g); comparisons++;
    if (g !== e) begin mismatches++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end
endtask
task wr(logic [7:0] a, d); t; {reg_wr_in, reg_addr_in, reg_wdata_in} <= {1'b1, a, d};
    t; reg_wr_in <= 0; if (a == 8'ha7) s[0] = d; if (a == 8'hcf) en = d[0];
    #1 cmp("enable", {7'h0, en}, {7'h0, auto_en_out});
endtask
task rd(logic [7:0] a, e); t; {reg_rd_in, reg_addr_in} <= {1'b1, a};
    t; reg_rd_in <= 0; #1 cmp("rdata", e, reg_rdata_out); endtask
task irq(bit x); r = nx(r); src.fire(x, r[7:0]);
    if (en && !x) begin for (i = 4; i > 0; i--) s[i] = s[i-1]; s[0] = r[7:0]; end
    if (en && x) begin for (i = 0; i < 4; i++) s[i] = s[i+1]; s[4] = 8'h00; end
    #1 cmp("page", s[0], active_page_out); endtask
initial begin
    t; t; sys_rst_in <= 0;
    rd(8'hcf, 8'h01); rd(8'ha7, 8'h00);
    repeat (6) irq(0);
    for (j = 0; j < 6; j++) begin wr(8'hcf, {1'b0, j[2:0], 4'h1});
        rd(8'hd7, j < 5 ? s[j] : 8'h00); end
    repeat (6) irq(1);
    wr(8'ha7, 8'h3c); wr(8'hcf, 8'h70); irq(0); irq(1); rd(8'hcf, 8'h70);
    rd(8'h55, 8'h00); wr(8'hcf, 8'h01); irq(0); irq(1);
    t; clk_en_in <= 0; src.fire(0, 8'h5a);
    #1 cmp("frozen", s[0], active_page_out);
    t; clk_en_in <= 1;
    test_done;
end
endmodule
`default_nettype wire
